//--- hdl/dcs_pkg.sv
// Constants for the distributed-clock loop and sync activation group
package dcs_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses, LSB at lowest address)
   // ------------------------------------------------------------
   localparam logic [11:0] OFF_BW_LO = 12'h930;
   localparam logic [11:0] OFF_BW_HI = 12'h931;
   localparam logic [11:0] OFF_SPD_LO = 12'h932;
   localparam logic [11:0] OFF_SPD_HI = 12'h933;
   localparam logic [11:0] OFF_TDEPTH = 12'h934;
   localparam logic [11:0] OFF_SDEPTH = 12'h935;
   localparam logic [11:0] OFF_OWN = 12'h980;
   localparam logic [11:0] OFF_ACT = 12'h981;
   localparam logic [11:0] OFF_START = 12'h990;
   localparam logic [11:0] OFF_CYCLE = 12'h9a0;
   localparam logic [11:0] START_EXT_BYTE = 12'h993;
   localparam logic [11:0] START_TOP_BYTE = 12'h997;

   // ------------------------------------------------------------
   // Reset values and field masks
   // ------------------------------------------------------------
   localparam logic [14:0] BW_RST = 15'h1000;
   localparam logic [15:0] SPD_RST = 16'h0000;
   localparam logic [3:0] TDEPTH_RST = 4'h4;
   localparam logic [3:0] SDEPTH_RST = 4'hc;
   localparam logic [7:0] OWN_RST = 8'h00;
   localparam logic [7:0] OWN_MASK = 8'h31;
   localparam logic [7:0] ACT_RST = 8'h00;
   localparam logic [15:0] SPD_MARGIN = 16'h007f;

   // ------------------------------------------------------------
   // Bit positions
   // ------------------------------------------------------------
   localparam int OWN_SYNC = 0;
   localparam int OWN_LATCH0 = 4;
   localparam int OWN_LATCH1 = 5;
   localparam int ACT_UNIT = 0;
   localparam int ACT_GEN_FIRST = 1;
   localparam int ACT_GEN_SECOND = 2;
   localparam int ACT_AUTO = 3;
   localparam int ACT_EXT = 4;
   localparam int ACT_CHECK = 5;
   localparam int ACT_NEAR = 6;
   localparam int ACT_DEBUG = 7;

   // Short near-future window is 2^31 ns
   localparam logic [63:0] NEAR_SHORT = 64'h0000_0000_8000_0000;

   // ------------------------------------------------------------
   // Sync generator states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      SG_IDLE = 4'b0001,
      SG_WAIT = 4'b0010,
      SG_RUN = 4'b0100,
      SG_DONE = 4'b1000
   } dcs_sg_state_t;
endpackage : dcs_pkg

//--- hdl/dcs_avg_filter.sv
// Running-average filter with a power-of-two depth and a clear input
`timescale 1ns/100ps
module dcs_avg_filter #(
   parameter int W = 32
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic clear,
   input wire logic sample_valid,
   input wire logic signed [W-1:0] sample,
   input wire logic [3:0] depth,
   output logic signed [W-1:0] avg
);
   logic signed [W-1:0] avg_r;
   logic signed [W-1:0] avg_nxt;
   logic signed [W:0] delta;

   // Extra bit keeps the difference from wrapping
   always_comb begin
      delta = {sample[W-1], sample} - {avg_r[W-1], avg_r};
      avg_nxt = avg_r;
      if (clear) begin
         avg_nxt = '0;
      end else if (sample_valid) begin
         avg_nxt = avg_r + W'(delta >>> depth);
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         avg_r <= '0;
      end else begin
         avg_r <= avg_nxt;
      end
   end

   assign avg = avg_r;
endmodule : dcs_avg_filter

//--- hdl/dcs_sync_gen.sv
// Start-time and cycle scheduler for both sync outputs
`timescale 1ns/100ps
module dcs_sync_gen (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic active,
   input wire logic check_en,
   input wire logic near_short,
   input wire logic [63:0] start_time,
   input wire logic [31:0] cycle_time,
   input wire logic [63:0] sys_time,
   output logic fire,
   output logic [63:0] next_time,
   output logic out_of_near
);
   dcs_pkg::dcs_sg_state_t st_r;
   dcs_pkg::dcs_sg_state_t st_nxt;
   logic [63:0] next_r;
   logic [63:0] next_nxt;
   logic fire_nxt;
   logic fire_r;
   logic oon_r;
   logic oon_nxt;
   logic [63:0] ahead;
   logic [63:0] late;
   logic outside;

   always_comb begin
      ahead = start_time - sys_time;
      late = sys_time - next_r;
      outside = near_short ? (ahead >= dcs_pkg::NEAR_SHORT) : ahead[63];
      st_nxt = st_r;
      next_nxt = next_r;
      fire_nxt = 1'b0;
      oon_nxt = oon_r;
      case (st_r)
         dcs_pkg::SG_IDLE: begin
            if (active) begin
               oon_nxt = outside;
               next_nxt = start_time;
               st_nxt = dcs_pkg::SG_WAIT;
               if (check_en && outside) begin
                  next_nxt = sys_time;
               end
            end
         end
         dcs_pkg::SG_WAIT, dcs_pkg::SG_RUN: begin
            if (!late[63]) begin
               fire_nxt = 1'b1;
               next_nxt = next_r + {32'h0000_0000, cycle_time};
               st_nxt = (cycle_time == 32'h0000_0000) ? dcs_pkg::SG_DONE : dcs_pkg::SG_RUN;
            end
         end
         dcs_pkg::SG_DONE: begin
            st_nxt = dcs_pkg::SG_DONE;
         end
         default: begin
            st_nxt = dcs_pkg::SG_IDLE;
         end
      endcase
      if (!active) begin
         st_nxt = dcs_pkg::SG_IDLE;
         fire_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= dcs_pkg::SG_IDLE;
         next_r <= 64'h0000_0000_0000_0000;
         fire_r <= 1'b0;
         oon_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         next_r <= next_nxt;
         fire_r <= fire_nxt;
         oon_r <= oon_nxt;
      end
   end

   assign fire = fire_r;
   assign next_time = next_r;
   assign out_of_near = oon_r;
endmodule : dcs_sync_gen

//--- hdl/dcs_loop_sync_regs.sv
// Loop tuning, unit ownership and sync activation registers
//
// Operation
// - Bandwidth 15 bits, reset 1000h, network writes
// - Bandwidth write clears difference and deviation
// - Deviation is signed 16-bit, reset zero
// - Deviation clamped to bandwidth minus 7Fh
// - Time filter depth 4 bits, write clears
// - Speed filter depth reset Ch, write resets
// - Bit 5 owns latch one and interrupt
// - Bit 4 owns latch zero, forced host
// - Bit 0 owns sync unit, network-only writes
// - Activation writable only by sync owner
// - Bit 7 fires one debug pulse
// - Bit 6 selects near-future window
// - Bit 5 starts immediately when outside window
// - Bit 4 extends 32-bit start time
// - Bit 3 auto-activates on start write
// - Bits 2,1 enable second, first outputs
// - Zero cycle time gives single shot
// - Start time writable when owner bit zero
`timescale 1ns/100ps
module dcs_loop_sync_regs (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [11:0] network_side_addr,
   input wire logic network_side_wr,
   input wire logic network_side_rd,
   input wire logic [7:0] network_side_wdata,
   output logic [7:0] network_side_rdata,
   output logic network_side_rvalid,
   input wire logic [11:0] host_side_interface_addr,
   input wire logic host_side_interface_wr,
   input wire logic host_side_interface_rd,
   input wire logic [7:0] host_side_interface_wdata,
   output logic [7:0] host_side_interface_rdata,
   output logic host_side_interface_rvalid,
   input wire logic [63:0] sys_time,
   input wire logic sys_time_host_ctrl,
   input wire logic time_diff_valid,
   input wire logic signed [31:0] time_diff_sample,
   input wire logic speed_err_valid,
   input wire logic signed [15:0] speed_err_sample,
   input wire logic latch0_event,
   input wire logic latch1_event,
   output logic signed [31:0] sys_time_diff,
   output logic [14:0] loop_bandwidth,
   output logic signed [15:0] clock_speed_deviation,
   output logic latch0_irq_network_side,
   output logic latch0_irq_host_side_interface,
   output logic latch1_irq_network_side,
   output logic latch1_irq_host_side_interface,
   output logic sync_output_first,
   output logic sync_output_second
);
   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [14:0] bw_r, bw_nxt;
   logic [3:0] tdepth_r, tdepth_nxt;
   logic [3:0] sdepth_r, sdepth_nxt;
   logic [7:0] own_r, own_nxt;
   logic [7:0] act_r, act_nxt;
   logic [63:0] start_r, start_nxt;
   logic [31:0] cycle_r, cycle_nxt;
   logic signed [15:0] spd_r, spd_nxt;
   logic [7:0] net_rdata_r, net_rdata_nxt;
   logic [7:0] host_rdata_r, host_rdata_nxt;
   logic net_rvalid_r, host_rvalid_r;
   logic l0n_r, l0h_r, l1n_r, l1h_r;
   logic l0n_nxt, l0h_nxt, l1n_nxt, l1h_nxt;
   logic s1_r, s2_r, s1_nxt, s2_nxt;

   // ------------------------------------------------------------
   // Write port selection
   // ------------------------------------------------------------
   // One write per cycle; network side wins a same-cycle collision
   logic w_en;
   logic w_host;
   logic [11:0] w_addr;
   logic [7:0] w_data;
   logic own_ok;
   logic clr_tdiff, clr_spd, clr_sfilt;
   logic start_commit;
   logic dbg_fire;
   logic own_latch0;
   logic gen_fire;
   logic [63:0] gen_next;
   logic gen_oon;
   logic signed [15:0] spd_filt;
   logic signed [15:0] spd_lim;

   always_comb begin
      w_en = network_side_wr | host_side_interface_wr;
      w_host = !network_side_wr;
      w_addr = network_side_wr ? network_side_addr : host_side_interface_addr;
      w_data = network_side_wr ? network_side_wdata : host_side_interface_wdata;
      own_ok = (w_host == own_r[dcs_pkg::OWN_SYNC]);
   end

   function automatic logic in_range(input logic [11:0] a, input logic [11:0] base,
                                     input logic [11:0] len);
      in_range = (a >= base) && (a < base + len);
   endfunction : in_range

   function automatic logic [7:0] byte_of64(input logic [63:0] v, input logic [2:0] idx);
      byte_of64 = v[{idx, 3'b000} +: 8];
   endfunction : byte_of64

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always_comb begin
      bw_nxt = bw_r;
      tdepth_nxt = tdepth_r;
      sdepth_nxt = sdepth_r;
      own_nxt = own_r;
      act_nxt = act_r;
      start_nxt = start_r;
      cycle_nxt = cycle_r;
      clr_tdiff = 1'b0;
      clr_spd = 1'b0;
      clr_sfilt = 1'b0;
      start_commit = 1'b0;
      dbg_fire = 1'b0;
      if (w_en && !w_host) begin
         if (w_addr == dcs_pkg::OFF_BW_LO) begin
            bw_nxt[7:0] = w_data;
         end
         if (w_addr == dcs_pkg::OFF_BW_HI) begin
            bw_nxt[14:8] = w_data[6:0];
         end
         if (w_addr == dcs_pkg::OFF_BW_LO || w_addr == dcs_pkg::OFF_BW_HI) begin
            clr_tdiff = 1'b1;
            clr_spd = 1'b1;
         end
         if (w_addr == dcs_pkg::OFF_TDEPTH) begin
            tdepth_nxt = w_data[3:0];
            clr_tdiff = 1'b1;
         end
         if (w_addr == dcs_pkg::OFF_SDEPTH) begin
            sdepth_nxt = w_data[3:0];
            clr_sfilt = 1'b1;
         end
         if (w_addr == dcs_pkg::OFF_OWN) begin
            own_nxt = w_data & dcs_pkg::OWN_MASK;
         end
      end
      if (w_en && own_ok) begin
         if (w_addr == dcs_pkg::OFF_ACT) begin
            act_nxt = w_data;
            dbg_fire = w_data[dcs_pkg::ACT_DEBUG];
         end
         if (in_range(w_addr, dcs_pkg::OFF_CYCLE, 12'h004)) begin
            cycle_nxt[{w_addr[1:0], 3'b000} +: 8] = w_data;
         end
      end
      // start time only while network owns unit
      if (w_en && !w_host && !own_r[dcs_pkg::OWN_SYNC]
          && in_range(w_addr, dcs_pkg::OFF_START, 12'h008)) begin
         start_nxt[{w_addr[2:0], 3'b000} +: 8] = w_data;
         if (w_addr == dcs_pkg::START_EXT_BYTE && act_r[dcs_pkg::ACT_EXT]) begin
            start_nxt[63:32] = sys_time[63:32]
               + {31'h0, (start_nxt[31:0] < sys_time[31:0])};
            start_commit = 1'b1;
         end
         if (w_addr == dcs_pkg::START_TOP_BYTE) begin
            start_commit = 1'b1;
         end
      end
      if (start_commit && act_nxt[dcs_pkg::ACT_AUTO]) begin
         act_nxt[dcs_pkg::ACT_UNIT] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bw_r <= dcs_pkg::BW_RST;
         tdepth_r <= dcs_pkg::TDEPTH_RST;
         sdepth_r <= dcs_pkg::SDEPTH_RST;
         own_r <= dcs_pkg::OWN_RST;
         act_r <= dcs_pkg::ACT_RST;
         start_r <= 64'h0000_0000_0000_0000;
         cycle_r <= 32'h0000_0000;
      end else begin
         bw_r <= bw_nxt;
         tdepth_r <= tdepth_nxt;
         sdepth_r <= sdepth_nxt;
         own_r <= own_nxt;
         act_r <= act_nxt;
         start_r <= start_nxt;
         cycle_r <= cycle_nxt;
      end
   end

   // ------------------------------------------------------------
   // Loop filters and speed deviation
   // ------------------------------------------------------------
   // difference filter cleared
   dcs_avg_filter #(.W(32)) u_tdiff (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .clear(clr_tdiff),
      .sample_valid(time_diff_valid),
      .sample(time_diff_sample),
      .depth(tdepth_r),
      .avg(sys_time_diff)
   );

   dcs_avg_filter #(.W(16)) u_speed (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .clear(clr_sfilt | clr_spd),
      .sample_valid(speed_err_valid),
      .sample(speed_err_sample),
      .depth(sdepth_r),
      .avg(spd_filt)
   );

   always_comb begin
      spd_lim = signed'({1'b0, bw_r} - dcs_pkg::SPD_MARGIN);
      spd_nxt = spd_filt;
      if (spd_filt > spd_lim) begin
         spd_nxt = spd_lim;
      end else if (spd_filt < -spd_lim) begin
         spd_nxt = -spd_lim;
      end
      if (clr_spd) begin
         spd_nxt = dcs_pkg::SPD_RST;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         spd_r <= dcs_pkg::SPD_RST;
      end else begin
         spd_r <= spd_nxt;
      end
   end

   // ------------------------------------------------------------
   // Sync scheduling and outputs
   // ------------------------------------------------------------
   // window, check and single shot
   dcs_sync_gen u_gen (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .active(act_r[dcs_pkg::ACT_UNIT]),
      .check_en(act_r[dcs_pkg::ACT_CHECK]),
      .near_short(act_r[dcs_pkg::ACT_NEAR]),
      .start_time(start_r),
      .cycle_time(cycle_r),
      .sys_time(sys_time),
      .fire(gen_fire),
      .next_time(gen_next),
      .out_of_near(gen_oon)
   );

   always_comb begin
      s1_nxt = gen_fire & act_r[dcs_pkg::ACT_GEN_FIRST];
      s2_nxt = gen_fire & act_r[dcs_pkg::ACT_GEN_SECOND];
      if (dbg_fire) begin
         s1_nxt = s1_nxt | w_data[dcs_pkg::ACT_GEN_FIRST];
         s2_nxt = s2_nxt | w_data[dcs_pkg::ACT_GEN_SECOND];
      end
      // host-timed system forces host latch zero
      own_latch0 = own_r[dcs_pkg::OWN_LATCH0] | sys_time_host_ctrl;
      l0n_nxt = latch0_event & !own_latch0;
      l0h_nxt = latch0_event & own_latch0;
      l1n_nxt = latch1_event & !own_r[dcs_pkg::OWN_LATCH1];
      l1h_nxt = latch1_event & own_r[dcs_pkg::OWN_LATCH1];
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         l0n_r <= 1'b0;
         l0h_r <= 1'b0;
         l1n_r <= 1'b0;
         l1h_r <= 1'b0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         l0n_r <= l0n_nxt;
         l0h_r <= l0h_nxt;
         l1n_r <= l1n_nxt;
         l1h_r <= l1h_nxt;
      end
   end

   // ------------------------------------------------------------
   // Read decode
   // ------------------------------------------------------------
   // unmapped and reserved bits read zero
   function automatic logic [7:0] rd_byte(input logic [11:0] a);
      logic [7:0] own_view;
      own_view = own_r;
      own_view[dcs_pkg::OWN_LATCH0] = own_r[dcs_pkg::OWN_LATCH0] | sys_time_host_ctrl;
      rd_byte = 8'h00;
      if (a == dcs_pkg::OFF_BW_LO) rd_byte = bw_r[7:0];
      if (a == dcs_pkg::OFF_BW_HI) rd_byte = {1'b0, bw_r[14:8]};
      if (a == dcs_pkg::OFF_SPD_LO) rd_byte = spd_r[7:0];
      if (a == dcs_pkg::OFF_SPD_HI) rd_byte = spd_r[15:8];
      if (a == dcs_pkg::OFF_TDEPTH) rd_byte = {4'h0, tdepth_r};
      if (a == dcs_pkg::OFF_SDEPTH) rd_byte = {4'h0, sdepth_r};
      if (a == dcs_pkg::OFF_OWN) rd_byte = own_view;
      if (a == dcs_pkg::OFF_ACT) rd_byte = act_r;
      if (in_range(a, dcs_pkg::OFF_START, 12'h008)) rd_byte = byte_of64(gen_next, a[2:0]);
      if (in_range(a, dcs_pkg::OFF_CYCLE, 12'h004)) rd_byte = cycle_r[{a[1:0], 3'b000} +: 8];
   endfunction : rd_byte

   always_comb begin
      net_rdata_nxt = network_side_rd ? rd_byte(network_side_addr) : net_rdata_r;
      host_rdata_nxt = host_side_interface_rd ? rd_byte(host_side_interface_addr)
                                              : host_rdata_r;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         net_rdata_r <= 8'h00;
         host_rdata_r <= 8'h00;
         net_rvalid_r <= 1'b0;
         host_rvalid_r <= 1'b0;
      end else begin
         net_rdata_r <= net_rdata_nxt;
         host_rdata_r <= host_rdata_nxt;
         net_rvalid_r <= network_side_rd;
         host_rvalid_r <= host_side_interface_rd;
      end
   end

   assign network_side_rdata = net_rdata_r;
   assign network_side_rvalid = net_rvalid_r;
   assign host_side_interface_rdata = host_rdata_r;
   assign host_side_interface_rvalid = host_rvalid_r;
   assign loop_bandwidth = bw_r;
   assign clock_speed_deviation = spd_r;
   assign latch0_irq_network_side = l0n_r;
   assign latch0_irq_host_side_interface = l0h_r;
   assign latch1_irq_network_side = l1n_r;
   assign latch1_irq_host_side_interface = l1h_r;
   assign sync_output_first = s1_r;
   assign sync_output_second = s2_r;

   // Kept for a future status view of the plausibility result
   logic oon_unused;
   assign oon_unused = gen_oon;
endmodule : dcs_loop_sync_regs

//--- test/dcs_loop_sync_chk.sv
// Checker of the loop tuning and sync activation registers
`timescale 1ns/100ps
module dcs_loop_sync_chk (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [11:0] network_side_addr,
   input wire logic network_side_wr,
   input wire logic network_side_rd,
   input wire logic [7:0] network_side_wdata,
   input wire logic [7:0] network_side_rdata,
   input wire logic network_side_rvalid,
   input wire logic host_side_interface_wr,
   input wire logic sys_time_host_ctrl,
   input wire logic latch0_event,
   input wire logic latch1_event,
   input wire logic signed [31:0] sys_time_diff,
   input wire logic [14:0] loop_bandwidth,
   input wire logic signed [15:0] clock_speed_deviation,
   input wire logic latch0_irq_network_side,
   input wire logic latch0_irq_host_side_interface,
   input wire logic latch1_irq_network_side,
   input wire logic latch1_irq_host_side_interface,
   input wire logic sync_output_first,
   input wire logic sync_output_second
);
   // ----
   // Sync owner shadow, network writes only
   // ----
   logic own0_r;
   logic own0_nxt;
   logic [7:0] dev_lo;
   logic signed [15:0] lim;
   assign dev_lo = clock_speed_deviation[7:0];
   assign lim = $signed({1'b0, loop_bandwidth}) - 16'sh007f;
   always_comb begin
      own0_nxt = own0_r;
      if (network_side_wr && network_side_addr == dcs_pkg::OFF_OWN) begin
         own0_nxt = network_side_wdata[0];
      end
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) own0_r <= 1'b0;
      else own0_r <= own0_nxt;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence s_net_wr(a);
      network_side_wr && network_side_addr == a;
   endsequence
   sequence s_dbg(b);
      s_net_wr(dcs_pkg::OFF_ACT) ##0 !own0_r && network_side_wdata[7] && network_side_wdata[b];
   endsequence
   a_bw_clear: assert property (s_net_wr(dcs_pkg::OFF_BW_HI) |=> clock_speed_deviation == 0)
      else $error("deviation kept after bandwidth write");
   a_bw_net_wr: assert property (s_net_wr(dcs_pkg::OFF_BW_LO) |=>
      loop_bandwidth[7:0] == $past(network_side_wdata))
      else $error("bandwidth low byte not written");
   a_bw_host_ro: assert property (host_side_interface_wr && !network_side_wr |=>
      $stable(loop_bandwidth))
      else $error("host changed bandwidth");
   a_dev_clamp: assert property (loop_bandwidth < 15'h0080 ||
      (clock_speed_deviation <= lim && clock_speed_deviation >= -lim))
      else $error("deviation outside clamp");
   a_tdepth_clear: assert property (s_net_wr(dcs_pkg::OFF_TDEPTH) |=> sys_time_diff == 0)
      else $error("difference kept after depth write");
   a_latch1_route: assert property (1'b1 |=>
      ($past(latch1_event) == (latch1_irq_network_side || latch1_irq_host_side_interface))
      && !(latch1_irq_network_side && latch1_irq_host_side_interface))
      else $error("latch one interrupt misrouted");
   a_latch0_host: assert property (sys_time_host_ctrl && latch0_event |=>
      latch0_irq_host_side_interface && !latch0_irq_network_side)
      else $error("latch zero interrupt not to host");
   a_dbg_first: assert property (s_dbg(1) |=> sync_output_first)
      else $error("no debug pulse on first output");
   a_dbg_second: assert property (s_dbg(2) |=> sync_output_second)
      else $error("no debug pulse on second output");
   a_dev_read: assert property (network_side_rd &&
      network_side_addr == dcs_pkg::OFF_SPD_LO |=>
      network_side_rvalid && network_side_rdata == $past(dev_lo))
      else $error("deviation read wrong");
endmodule : dcs_loop_sync_chk

//--- test/dcs_time_src.sv
// Model of the time source and the event traffic around the block
`timescale 1ns/100ps
module dcs_time_src (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic en,
   output logic [63:0] sys_time,
   output logic tv,
   output logic signed [31:0] ts,
   output logic sv,
   output logic signed [15:0] ss,
   output logic l0,
   output logic l1
);
   // Upper word nonzero so a missing start extension shows
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sys_time <= 64'h0000_0005_0000_0000;
         {tv, ts, sv, ss, l0, l1} <= '0;
      end else begin
         sys_time <= sys_time + 64'h0a;
         tv <= en && $urandom_range(3) == 0;
         ts <= $urandom;
         sv <= en && $urandom_range(3) == 0;
         ss <= 16'($urandom);
         l0 <= $urandom_range(7) == 0;
         l1 <= $urandom_range(7) == 0;
      end
   end
endmodule : dcs_time_src

//--- test/test_dc_loop_and_sync_activation.sv
// Self-checking bench of the loop tuning and sync activation registers
`timescale 1ns/100ps
module test_dc_loop_and_sync_activation;
   logic ref_clk, nrst, nw, nr, hw, hr, hc, en;
   logic [11:0] na, ha, a;
   logic [7:0] nd, hd, ds;
   logic [15:0] v;
   logic [63:0] t;
   wire [7:0] nq, hq;
   wire nv, hv, s1, s2, tv, sv, l0, l1;
   wire [63:0] st;
   wire signed [31:0] ts;
   wire signed [15:0] ss;
   int fails, n_tests, cyc, p1, p2, q1, q2;
   logic [11:0] ra [9] = '{12'h930, 12'h931, 12'h932, 12'h933, 12'h934, 12'h935, 12'h980,
      12'h981, 12'h936};
   logic [7:0] rv [9] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h04, 8'h0c, 8'h00, 8'h00, 8'h00};
   dcs_time_src dcs_time_src_i (.ref_clk, .nrst, .en, .sys_time(st), .tv, .ts, .sv, .ss, .l0, .l1);
   dcs_loop_sync_regs dcs_loop_sync_regs_i (.ref_clk, .nrst, .network_side_addr(na),
      .network_side_wr(nw), .network_side_rd(nr), .network_side_wdata(nd),
      .network_side_rdata(nq), .network_side_rvalid(nv), .host_side_interface_addr(ha),
      .host_side_interface_wr(hw), .host_side_interface_rd(hr), .host_side_interface_wdata(hd),
      .host_side_interface_rdata(hq), .host_side_interface_rvalid(hv), .sys_time(st),
      .sys_time_host_ctrl(hc), .time_diff_valid(tv), .time_diff_sample(ts),
      .speed_err_valid(sv), .speed_err_sample(ss), .latch0_event(l0), .latch1_event(l1),
      .sys_time_diff(), .loop_bandwidth(), .clock_speed_deviation(),
      .latch0_irq_network_side(), .latch0_irq_host_side_interface(),
      .latch1_irq_network_side(), .latch1_irq_host_side_interface(),
      .sync_output_first(s1), .sync_output_second(s2));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Pulse counters and hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      p1 <= p1 + int'(s1);
      p2 <= p2 + int'(s2);
      if (cyc == 5000) begin
         fails++;
         stop_test();
      end
   end
   task chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task wr(input bit h, input logic [11:0] ad, input logic [7:0] d);
      @(posedge ref_clk);
      na <= ad;
      ha <= ad;
      nd <= d;
      hd <= d;
      nw <= !h;
      hw <= h;
      @(posedge ref_clk);
      nw <= 1'b0;
      hw <= 1'b0;
   endtask : wr
   task rd(input bit h, input logic [11:0] ad, input logic [7:0] e);
      @(posedge ref_clk);
      na <= ad;
      ha <= ad;
      nr <= !h;
      hr <= h;
      @(posedge ref_clk);
      nr <= 1'b0;
      hr <= 1'b0;
      #1;
      chk(h ? {hv, hq} : {nv, nq}, {1'b1, e});
   endtask : rd
   function automatic logic [7:0] rmask(input logic [11:0] ad, input logic [7:0] d);
      case (ad)
         12'h931: return d & 8'h7f;
         12'h934, 12'h935: return d & 8'h0f;
         12'h980: return d & 8'h31;
         default: return d;
      endcase
   endfunction : rmask
   task stop_test();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   initial begin
      {nrst, nw, nr, hw, hr, hc, en, na, ha, nd, hd} = '0;
      void'($urandom(32'hf9f74d0e));
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      foreach (ra[i]) rd(i % 2, ra[i], rv[i]);
      $display("reset test done");
      en <= 1'b1;
      hc <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         // range corners first, top bit clear
         v = i == 0 ? 16'h0080 : i == 1 ? 16'h3fff : 16'($urandom_range(16'h3fff, 16'h0080));
         wr(0, 12'h930, v[7:0]);
         wr(0, 12'h931, v[15:8]);
         wr(1, 12'h930, ~v[7:0]);
         rd(0, 12'h930, v[7:0]);
         rd(1, 12'h931, v[15:8]);
      end
      en <= 1'b0;
      hc <= 1'b0;
      wr(0, 12'h931, 8'h20);
      rd(0, 12'h932, 8'h00);
      rd(1, 12'h933, 8'h00);
      en <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         ds = 8'($urandom);
         a = 12'h934 + 12'(i % 2);
         wr(0, a, ds);
         wr(1, a, ~ds);
         rd(i % 2, a, rmask(a, ds));
      end
      $display("loop test done");
      wr(0, 12'h980, 8'hff);
      wr(1, 12'h980, 8'h00);
      rd(1, 12'h980, rmask(12'h980, 8'hff));
      q1 = p1;
      q2 = p2;
      wr(0, 12'h981, 8'h84);
      wr(1, 12'h981, 8'h82);
      rd(0, 12'h981, 8'h82);
      chk(16'(p1 - q1), 16'h0001);
      chk(16'(p2 - q2), 16'h0000);
      wr(0, 12'h980, 8'h00);
      for (int g = 1; g < 4; g++) begin
         q1 = p1;
         q2 = p2;
         wr(0, 12'h981, 8'(8'h80 | g << 1));
         repeat (2) @(posedge ref_clk);
         chk(16'(p1 - q1), 16'(g & 1));
         chk(16'(p2 - q2), 16'(g >> 1));
      end
      wr(1, 12'h981, 8'h82);
      rd(1, 12'h981, 8'h86);
      $display("owner test done");
      wr(0, 12'h981, 8'h1e);
      t = st + 64'd3000;
      for (int i = 0; i < 4; i++) wr(0, 12'h990 + 12'(i), t[8*i +: 8]);
      rd(0, 12'h981, 8'h1f);
      q1 = p1;
      q2 = p2;
      repeat (100) @(posedge ref_clk);
      chk(16'(p1 - q1), 16'h0000);
      repeat (400) @(posedge ref_clk);
      chk(16'(p1 - q1), 16'h0001);
      chk(16'(p2 - q2), 16'h0001);
      rd(0, 12'h990, t[7:0]);
      wr(0, 12'h981, 8'h00);
      t = st + 64'h1_0000_0000;
      for (int i = 0; i < 8; i++) wr(0, 12'h990 + 12'(i), t[8*i +: 8]);
      for (int m = 0; m < 2; m++) begin
         q1 = p1;
         wr(0, 12'h981, 8'h26 | 8'(m << 6));
         wr(0, 12'h981, 8'h27 | 8'(m << 6));
         repeat (20) @(posedge ref_clk);
         chk(16'(p1 - q1), 16'(m));
      end
      $display("start test done");
      stop_test();
   end
endmodule : test_dc_loop_and_sync_activation
bind dcs_loop_sync_regs dcs_loop_sync_chk dcs_loop_sync_chk_i (.*);
